/* design/aer_uncorr_pkg.sv */
// Constants and carrier types for the uncorrectable error register bank
package aer_uncorr_pkg;

   // Register offsets as seen in configuration space
   localparam logic [11:0] NEXT_CAP_VERSION_OFFSET = 12'h102;
   localparam logic [11:0] FLAGS_OFFSET = 12'h104;
   localparam logic [11:0] SUPPRESS_OFFSET = 12'h108;

   // Next-capability/version word fields
   localparam logic [11:0] NEXT_CAP_POINTER = 12'h000;
   localparam logic [3:0] CAP_VERSION = 4'h1;

   // Reset values
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
   localparam logic [31:0] SUPPRESS_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_NONE = 32'h0000_0000;

   // Implemented bits: 20..12, 5 and 4; the rest read as zero
   localparam logic [31:0] IMPLEMENTED_BITS = 32'h001F_F030;

   // Bit positions of the error flags
   localparam int UNSUPPORTED_REQUEST_BIT = 20;
   localparam int END_TO_END_CRC_BIT = 19;
   localparam int MALFORMED_PACKET_BIT = 18;
   localparam int FLOW_CONTROL_OVERFLOW_BIT = 17;
   localparam int UNEXPECTED_COMPLETION_BIT = 16;
   localparam int COMPLETER_ABORT_BIT = 15;
   localparam int COMPLETION_TIMEOUT_BIT = 14;
   localparam int FLOW_CONTROL_VIOLATION_BIT = 13;
   localparam int POISONED_PACKET_BIT = 12;
   localparam int SURPRISE_DOWN_BIT = 5;
   localparam int DATA_LINK_PROTOCOL_BIT = 4;

   // Data width and lane width
   localparam int DATA_WIDTH = 32;
   localparam int LANE_WIDTH = 8;
   localparam int LANE_COUNT = 4;

   // One-cycle detection pulses from the port's error detectors
   typedef struct packed {
      logic unsupported_request;
      logic end_to_end_crc;
      logic malformed_packet;
      logic flow_control_overflow;
      logic unexpected_completion;
      logic completer_abort;
      logic completion_timeout;
      logic flow_control_violation;
      logic poisoned_packet;
      logic surprise_down;
      logic data_link_protocol;
   } error_events_type;

   // Configuration access request
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] address;
      logic [3:0] byte_enable;
      logic [31:0] write_data;
   } cfg_request_type;

   // Configuration access response
   typedef struct packed {
      logic ack;
      logic [31:0] read_data;
   } cfg_response_type;

endpackage : aer_uncorr_pkg

/* design/uncorr_flag_cell.sv */
// One status flag with its suppress bit and report pulse
`timescale 1ns/1ps
`default_nettype none

module uncorr_flag_cell (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Detection and software access
   input wire logic event_i,
   input wire logic clear_i,
   input wire logic suppress_write_i,
   input wire logic suppress_value_i,
   // State
   output logic flag_o,
   output logic suppress_o,
   output logic report_o
);

   logic flag_q;
   logic suppress_q;
   logic report_q;

   // Flag: set beats clear, zero writes do nothing
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~clear_i) | event_i;
      end
   end

   // Suppress bit
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         suppress_q <= 1'b0;
      end else if (suppress_write_i) begin
         suppress_q <= suppress_value_i;
      end
   end

   // Report only unsuppressed events
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         report_q <= 1'b0;
      end else begin
         report_q <= event_i & ~suppress_q;
      end
   end

   assign flag_o = flag_q;
   assign suppress_o = suppress_q;
   assign report_o = report_q;

endmodule : uncorr_flag_cell

`default_nettype wire

/* design/cfg_answer_reg.sv */
// Registered answer stage for configuration accesses
`timescale 1ns/1ps
`default_nettype none

module cfg_answer_reg (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Selected answer
   input wire logic take_i,
   input wire logic [31:0] data_i,
   // Registered response
   output aer_uncorr_pkg::cfg_response_type response_o
);

   aer_uncorr_pkg::cfg_response_type response_q;

   // One ack per request, data held until the next request
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         response_q.ack <= 1'b0;
         response_q.read_data <= aer_uncorr_pkg::READ_NONE;
      end else begin
         response_q.ack <= take_i;
         if (take_i) begin
            response_q.read_data <= data_i;
         end
      end
   end

   assign response_o = response_q;

endmodule : cfg_answer_reg

`default_nettype wire

/* design/aer_uncorrectable_error_regs.sv */
// Uncorrectable error status, suppress and version registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Next-capability pointer reads zero: chain ends
// - Capability version 1h in low nibble
// - Flags clear only on written ones
// - Reserved ranges read as zero
// - Bit zero is read-only, undefined
// - Bit 20 sets on unsupported request
// - Bit 19 sets on end-to-end CRC error
// - Bit 18 sets on malformed packet
// - Bit 17 sets on credit overflow
// - Bit 16 sets on unexpected completion
// - Bit 15 sets on completer abort
// - Bit 14 sets on completion timeout
// - Bit 13 sets on flow-control violation
// - Bit 12 sets on poisoned outgoing packet
// - Bit 5 sets on surprise link down
// - Bit 4 sets on data-link protocol error
// - Suppressed errors set flags, never reported
// - Suppress bits read/write, same positions
// - Status and suppress reset to zero
module aer_uncorrectable_error_regs (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Configuration access
   input wire aer_uncorr_pkg::cfg_request_type cfg_request_i,
   output aer_uncorr_pkg::cfg_response_type cfg_response_o,
   // Error detection pulses
   input wire aer_uncorr_pkg::error_events_type error_events_i,
   // Upstream report request
   output logic report_request_o,
   output logic [31:0] report_bits_o
);

   logic [31:0] event_vector;
   logic [31:0] flags;
   logic [31:0] suppress;
   logic [31:0] report_vector;
   logic [31:0] lane_enable;
   logic flags_write;
   logic suppress_write;
   logic [31:0] read_data;
   logic report_request_q;
   logic [31:0] report_bits_q;

   // Map detection pulses onto status bit positions
   always_comb begin
      event_vector = aer_uncorr_pkg::FLAGS_RESET;
      event_vector[aer_uncorr_pkg::UNSUPPORTED_REQUEST_BIT] =
         error_events_i.unsupported_request;
      event_vector[aer_uncorr_pkg::END_TO_END_CRC_BIT] =
         error_events_i.end_to_end_crc;
      event_vector[aer_uncorr_pkg::MALFORMED_PACKET_BIT] =
         error_events_i.malformed_packet;
      event_vector[aer_uncorr_pkg::FLOW_CONTROL_OVERFLOW_BIT] =
         error_events_i.flow_control_overflow;
      event_vector[aer_uncorr_pkg::UNEXPECTED_COMPLETION_BIT] =
         error_events_i.unexpected_completion;
      event_vector[aer_uncorr_pkg::COMPLETER_ABORT_BIT] =
         error_events_i.completer_abort;
      event_vector[aer_uncorr_pkg::COMPLETION_TIMEOUT_BIT] =
         error_events_i.completion_timeout;
      event_vector[aer_uncorr_pkg::FLOW_CONTROL_VIOLATION_BIT] =
         error_events_i.flow_control_violation;
      event_vector[aer_uncorr_pkg::POISONED_PACKET_BIT] =
         error_events_i.poisoned_packet;
      event_vector[aer_uncorr_pkg::SURPRISE_DOWN_BIT] =
         error_events_i.surprise_down;
      event_vector[aer_uncorr_pkg::DATA_LINK_PROTOCOL_BIT] =
         error_events_i.data_link_protocol;
   end

   // Write decode
   assign flags_write = cfg_request_i.valid & cfg_request_i.write &
      (cfg_request_i.address == aer_uncorr_pkg::FLAGS_OFFSET);
   assign suppress_write = cfg_request_i.valid & cfg_request_i.write &
      (cfg_request_i.address == aer_uncorr_pkg::SUPPRESS_OFFSET);

   // Per-bit cells; unimplemented bits stay zero
   genvar bit_index;
   generate
      for (bit_index = 0; bit_index < aer_uncorr_pkg::DATA_WIDTH; bit_index++) begin : g_bit
         assign lane_enable[bit_index] =
            cfg_request_i.byte_enable[bit_index / aer_uncorr_pkg::LANE_WIDTH];
         if (aer_uncorr_pkg::IMPLEMENTED_BITS[bit_index]) begin : g_cell
            uncorr_flag_cell u_cell (
               .clock_i(clock_i),
               .rst_i(rst_i),
               .event_i(event_vector[bit_index]),
               .clear_i(flags_write & lane_enable[bit_index] &
                  cfg_request_i.write_data[bit_index]),
               .suppress_write_i(suppress_write & lane_enable[bit_index]),
               .suppress_value_i(cfg_request_i.write_data[bit_index]),
               .flag_o(flags[bit_index]),
               .suppress_o(suppress[bit_index]),
               .report_o(report_vector[bit_index])
            );
         end else begin : g_reserved
            assign flags[bit_index] = 1'b0;
            assign suppress[bit_index] = 1'b0;
            assign report_vector[bit_index] = 1'b0;
         end
      end
   endgenerate

   // Read mux
   always_comb begin
      read_data = aer_uncorr_pkg::READ_NONE;
      unique case (cfg_request_i.address)
         aer_uncorr_pkg::NEXT_CAP_VERSION_OFFSET: begin
            read_data = 32'({aer_uncorr_pkg::NEXT_CAP_POINTER,
               aer_uncorr_pkg::CAP_VERSION});
         end
         aer_uncorr_pkg::FLAGS_OFFSET: begin
            read_data = flags & aer_uncorr_pkg::IMPLEMENTED_BITS;
         end
         aer_uncorr_pkg::SUPPRESS_OFFSET: begin
            read_data = suppress & aer_uncorr_pkg::IMPLEMENTED_BITS;
         end
         default: begin
            read_data = aer_uncorr_pkg::READ_NONE;
         end
      endcase
   end

   // Registered response
   cfg_answer_reg answer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .take_i(cfg_request_i.valid),
      .data_i(read_data),
      .response_o(cfg_response_o)
   );

   // Upstream report request, one pulse per unsuppressed event cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         report_request_q <= 1'b0;
         report_bits_q <= aer_uncorr_pkg::FLAGS_RESET;
      end else begin
         report_request_q <= |report_vector;
         report_bits_q <= report_vector;
      end
   end

   assign report_request_o = report_request_q;
   assign report_bits_o = report_bits_q;

endmodule : aer_uncorrectable_error_regs

`default_nettype wire

/* tb/aer_uncorr_checker_assertions.sv */
// Checker for the uncorrectable error register bank
`timescale 1ns/1ps
`default_nettype none

module aer_uncorr_checker (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Watched ports
   input wire aer_uncorr_pkg::cfg_request_type cfg_request_i,
   input wire aer_uncorr_pkg::cfg_response_type cfg_response_o,
   input wire aer_uncorr_pkg::error_events_type error_events_i,
   input wire logic report_request_o,
   input wire logic [31:0] report_bits_o
);
   logic [31:0] ev_bits;
   logic rd_req;
   logic rd_flags;
   assign ev_bits = {11'h000, error_events_i[10:2], 6'h00, error_events_i[1:0], 4'h0};
   assign rd_req = cfg_request_i.valid && !cfg_request_i.write;
   assign rd_flags = rd_req && cfg_request_i.address == aer_uncorr_pkg::FLAGS_OFFSET;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_ack; cfg_request_i.valid |=> cfg_response_o.ack; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_no_ack; !cfg_request_i.valid |=> !cfg_response_o.ack; endproperty
   a_no_ack: assert property (p_no_ack) else $error("answer without request");
   property p_ver;
      rd_req && cfg_request_i.address == aer_uncorr_pkg::NEXT_CAP_VERSION_OFFSET
      |=> cfg_response_o.read_data == 32'h0000_0001;
   endproperty
   a_ver: assert property (p_ver) else $error("version word wrong");
   property p_rsvd;
      rd_req && (rd_flags || cfg_request_i.address == aer_uncorr_pkg::SUPPRESS_OFFSET)
      |=> (cfg_response_o.read_data & ~aer_uncorr_pkg::IMPLEMENTED_BITS & 32'hFFFF_FFFE) == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
   property p_src;
      report_request_o |-> report_bits_o != 32'h0 && (report_bits_o & ~$past(ev_bits, 2)) == 32'h0;
   endproperty
   a_src: assert property (p_src) else $error("report without cause");
   property p_quiet; ev_bits == 0 |-> ##2 !report_request_o; endproperty
   a_quiet: assert property (p_quiet) else $error("report with no event");
   property p_flag20;
      error_events_i.unsupported_request ##1 (!cfg_request_i.valid)[*3] ##1 rd_flags
      |=> cfg_response_o.read_data[20];
   endproperty
   a_flag20: assert property (p_flag20) else $error("bit 20 not set");
   property p_flag4;
      error_events_i.data_link_protocol ##1 (!cfg_request_i.valid)[*3] ##1 rd_flags
      |=> cfg_response_o.read_data[4];
   endproperty
   a_flag4: assert property (p_flag4) else $error("bit 4 not set");
   c_ack: cover property (cfg_response_o.ack);
   c_report: cover property (report_request_o);
   c_flag: cover property (rd_flags ##1 cfg_response_o.read_data[20]);
endmodule : aer_uncorr_checker

bind aer_uncorrectable_error_regs aer_uncorr_checker u_checker (.clock_i(clock_i),
   .rst_i(rst_i), .cfg_request_i(cfg_request_i), .cfg_response_o(cfg_response_o),
   .error_events_i(error_events_i), .report_request_o(report_request_o),
   .report_bits_o(report_bits_o));

`default_nettype wire

/* tb/aer_uncorrectable_error_regs_test.sv */
// Self-checking bench for the uncorrectable error register bank
`timescale 1ns/1ps
`default_nettype none

module aer_uncorrectable_error_regs_test;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   aer_uncorr_pkg::cfg_request_type req = '0;
   aer_uncorr_pkg::cfg_response_type rsp;
   aer_uncorr_pkg::error_events_type ev = '0;
   logic rep;
   logic [31:0] rep_bits;
   logic [31:0] rd;
   logic [3:0] lanes = 4'hF;
   int miscompares = 0;
   int comparisons = 0;
   always #10 clock_i = ~clock_i;
   aer_uncorrectable_error_regs u_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_request_i(req),
      .cfg_response_o(rsp), .error_events_i(ev), .report_request_o(rep),
      .report_bits_o(rep_bits));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      req <= {1'b1, w, a, lanes, d};
      @(posedge clock_i);
      req <= '0;
      #1;
      chk({31'h0, rsp.ack}, 32'h1);
      rd = rsp.read_data;
   endtask : acc
   // Read, ignoring the undefined bit 0 of the two 32-bit registers
   task automatic look(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(a == 12'h102 ? rd : rd & 32'hFFFF_FFFE, exp);
   endtask : look
   task automatic pulse(input aer_uncorr_pkg::error_events_type v, input logic [31:0] exp);
      @(posedge clock_i);
      ev <= v;
      @(posedge clock_i);
      ev <= '0;
      @(posedge clock_i);
      #1;
      chk({31'h0, rep}, {31'h0, |exp});
      chk(rep_bits, exp);
      @(posedge clock_i);
      #1;
      chk({31'h0, rep}, 32'h0);
   endtask : pulse
   task automatic t_reset();
      look(12'h102, 32'h0000_0001);
      look(12'h104, 32'h0000_0000);
      look(12'h108, 32'h0000_0000);
      acc(1'b1, 12'h102, 32'hFFFF_FFFF);
      look(12'h102, 32'h0000_0001);
      look(12'h200, 32'h0000_0000);
   endtask : t_reset
   task automatic t_events();
      logic [31:0] m;
      for (int k = 0; k < 11; k++) begin
         m = 32'h1 << (k > 1 ? k + 10 : k + 4);
         pulse(aer_uncorr_pkg::error_events_type'(11'h001 << k), m);
         look(12'h104, m);
         acc(1'b1, 12'h104, ~m);
         look(12'h104, m);
         acc(1'b1, 12'h104, m);
         look(12'h104, 32'h0);
      end
   endtask : t_events
   // Event and clearing write in the same cycle: the set wins
   task automatic t_overlap();
      @(posedge clock_i);
      ev <= aer_uncorr_pkg::error_events_type'(11'h400);
      req <= {1'b1, 1'b1, aer_uncorr_pkg::FLAGS_OFFSET, 4'hF, 32'hFFFF_FFFF};
      @(posedge clock_i);
      ev <= '0;
      req <= '0;
      @(posedge clock_i);
      #1;
      chk(rep_bits, 32'h0010_0000);
      look(12'h104, 32'h0010_0000);
      acc(1'b1, 12'h104, 32'h0010_0000);
      look(12'h104, 32'h0);
   endtask : t_overlap
   // Byte lanes gate suppress writes; per-bit suppression of reports
   task automatic t_lanes();
      lanes = 4'h2;
      acc(1'b1, 12'h108, 32'hFFFF_FFFF);
      lanes = 4'hF;
      look(12'h108, 32'h0000_F000);
      pulse(aer_uncorr_pkg::error_events_type'(11'h404), 32'h0010_0000);
      look(12'h104, 32'h0010_1000);
      acc(1'b1, 12'h108, 32'h0);
      acc(1'b1, 12'h104, 32'hFFFF_FFFF);
      look(12'h104, 32'h0);
   endtask : t_lanes
   task automatic t_suppress();
      acc(1'b1, 12'h108, 32'hFFFF_FFFF);
      look(12'h108, aer_uncorr_pkg::IMPLEMENTED_BITS);
      pulse('1, 32'h0);
      look(12'h104, aer_uncorr_pkg::IMPLEMENTED_BITS);
      acc(1'b1, 12'h108, 32'h0);
      acc(1'b1, 12'h104, 32'hFFFF_FFFF);
      look(12'h104, 32'h0);
      acc(1'b1, 12'h108, 32'hFFFF_FFFF);
      pulse('1, 32'h0);
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      look(12'h104, 32'h0);
      look(12'h108, 32'h0);
   endtask : t_suppress
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_events();
      t_overlap();
      t_lanes();
      t_suppress();
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge clock_i);
      miscompares++;
      end_of_test();
   end
endmodule : aer_uncorrectable_error_regs_test

`default_nettype wire
